// File: acsq_pkg.sv
package acsq_pkg;
  // Master clock
  localparam int unsigned CLK_HZ        = 100_000_000;
  // Output data rates in conversions per second
  localparam int unsigned RATE_10_HZ    = 10;
  localparam int unsigned RATE_50_HZ    = 50;
  localparam int unsigned RATE_60_HZ    = 60;
  localparam int unsigned RATE_120_HZ   = 120;
  localparam int unsigned PERIOD_10_CYC  = CLK_HZ / RATE_10_HZ;
  localparam int unsigned PERIOD_50_CYC  = CLK_HZ / RATE_50_HZ;
  localparam int unsigned PERIOD_60_CYC  = CLK_HZ / RATE_60_HZ;
  localparam int unsigned PERIOD_120_CYC = CLK_HZ / RATE_120_HZ;
  // Rate pin patterns {high, low}
  localparam logic [1:0]  RATE_CODE_10  = 2'h3;
  localparam logic [1:0]  RATE_CODE_50  = 2'h2;
  localparam logic [1:0]  RATE_CODE_60  = 2'h1;
  localparam logic [1:0]  RATE_CODE_120 = 2'h0;
  // Gain pin patterns {high, low} and gain factors
  localparam logic [1:0]  GAIN_CODE_1   = 2'h0;
  localparam logic [1:0]  GAIN_CODE_8   = 2'h1;
  localparam logic [1:0]  GAIN_CODE_64  = 2'h2;
  localparam logic [7:0]  GAIN_X1       = 8'h01;
  localparam logic [7:0]  GAIN_X8       = 8'h08;
  localparam logic [7:0]  GAIN_X64      = 8'h40;
  localparam logic [7:0]  GAIN_X128     = 8'h80;
  // Settling is four conversion periods
  localparam logic [2:0]  SETTLE_CONV   = 3'h4;
  // Internal oscillator start-up after leaving power-down
  localparam int unsigned WAKE_US       = 1000;
  localparam int unsigned WAKE_CYC      = WAKE_US * (CLK_HZ / 1_000_000);
  // Least power-down pulse that resets the logic, rounded up
  localparam int unsigned SLEEP_RESET_PIN_MIN_NS  = 100;
  localparam logic [3:0]  SLEEP_RESET_PIN_MIN_CYC = 4'((SLEEP_RESET_PIN_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000);
  // Ready output returns high this long before an unread result is replaced
  localparam int unsigned RDY_GAP_NS    = 10_000;
  localparam logic [23:0] RDY_GAP_CYC   = 24'(RDY_GAP_NS / (1_000_000_000 / CLK_HZ));
  // Word width and offset binary mid-scale
  localparam int unsigned WORD_W        = 24;
  localparam logic [4:0]  WORD_LAST     = 5'h17;
  localparam logic [23:0] CODE_ZERO     = 24'h80_0000;
  // Pin vector positions after synchronisation
  localparam int unsigned PIN_SCLK      = 0;
  localparam int unsigned PIN_RATE_LO   = 1;
  localparam int unsigned PIN_RATE_HI   = 2;
  localparam int unsigned PIN_GAIN_LO   = 3;
  localparam int unsigned PIN_GAIN_HI   = 4;
  localparam int unsigned PIN_PAIR      = 5;
  localparam int unsigned PIN_TEMP      = 6;
  localparam int unsigned PIN_CLOCK_SOURCE_SELECT    = 7;
  localparam int unsigned PIN_SLEEP     = 8;
  localparam int unsigned PIN_N         = 9;
  // Register byte offsets
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_INJECT    = 8'h04;
  localparam logic [7:0]  REG_DATA      = 8'h08;
  localparam logic [7:0]  REG_STATUS    = 8'h0C;
  localparam logic [7:0]  REG_COUNT     = 8'h10;
  // Control register fields
  localparam int unsigned CTRL_INJECT   = 0;
  localparam int unsigned CTRL_RESTART  = 1;

  typedef enum logic [3:0] {
    ST_DOWN   = 4'h1,
    ST_WAKE   = 4'h2,
    ST_SETTLE = 4'h4,
    ST_RUN    = 4'h8
  } acsq_state_t;

  typedef enum logic [2:0] {
    SH_IDLE  = 3'h1,
    SH_WAIT  = 3'h2,
    SH_SHIFT = 3'h4
  } acsq_shift_t;
endpackage

// File: acsq_ser_if.sv
`timescale 1ns/100ps
interface acsq_ser_if;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        load;
  logic        abort;
  logic [23:0] word;
  logic        dout;
  logic        busy;
  logic        done;
  modport ctl (output sclk_rise, output sclk_fall, output load, output abort, output word,
               input dout, input busy, input done);
  modport shf (input sclk_rise, input sclk_fall, input load, input abort, input word,
               output dout, output busy, output done);
endinterface

// File: acsq_shift.sv
`timescale 1ns/100ps
module acsq_shift (
  input wire logic core_clk,
  input wire logic sys_rst,
  acsq_ser_if.shf  ser
);
  import acsq_pkg::*;

  typedef struct packed {
    acsq_shift_t phase;
    logic [23:0] sh;
    logic [4:0]  bits;
    logic        dout;
    logic        done;
  } acsq_shift_state_t;

  acsq_shift_state_t state_reg;
  acsq_shift_state_t state_next;

  always_comb begin
    state_next      = state_reg;
    state_next.done = 1'b0;
    if (ser.load) begin
      // Fresh result restarts the serial side and pulls ready low
      state_next.phase = SH_WAIT;
      state_next.sh    = ser.word;
      state_next.bits  = 5'h00;
      state_next.dout  = 1'b0;
    end else if (ser.abort) begin
      state_next.phase = SH_IDLE;
      state_next.dout  = 1'b1;
    end else begin
      case (state_reg.phase)
        SH_IDLE: begin
          state_next.dout = 1'b1;
        end
        SH_WAIT, SH_SHIFT: begin
          if (ser.sclk_fall) begin
            // Bit changes on falling edge, host takes it on rising edge
            state_next.dout  = state_reg.sh[WORD_W-1];
            state_next.sh    = {state_reg.sh[WORD_W-2:0], 1'b1};
            state_next.phase = SH_SHIFT;
          end else if (ser.sclk_rise && state_reg.phase == SH_SHIFT) begin
            if (state_reg.bits == WORD_LAST) begin
              // Each result can be read once; back to high when read
              state_next.phase = SH_IDLE;
              state_next.dout  = 1'b1;
              state_next.done  = 1'b1;
            end else begin
              state_next.bits = state_reg.bits + 5'h01;
            end
          end
        end
        default: begin
          state_next.phase = SH_IDLE;
          state_next.dout  = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_reg <= '{phase: SH_IDLE, sh: 24'h00_0000, bits: 5'h00, dout: 1'b1, done: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign ser.dout = state_reg.dout;
  assign ser.busy = (state_reg.phase == SH_SHIFT);
  assign ser.done = state_reg.done;
endmodule

// File: acsq_top.sv
`timescale 1ns/100ps
module acsq_top #(
  parameter logic [23:0] PERIOD_10_CYC  = 24'(acsq_pkg::PERIOD_10_CYC),
  parameter logic [23:0] PERIOD_50_CYC  = 24'(acsq_pkg::PERIOD_50_CYC),
  parameter logic [23:0] PERIOD_60_CYC  = 24'(acsq_pkg::PERIOD_60_CYC),
  parameter logic [23:0] PERIOD_120_CYC = 24'(acsq_pkg::PERIOD_120_CYC),
  parameter logic [23:0] WAKE_CYC       = 24'(acsq_pkg::WAKE_CYC)
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rate_select_low,
  input  wire logic        rate_select_high,
  input  wire logic        gain_select_low,
  input  wire logic        gain_select_high,
  input  wire logic        input_pair_select,
  input  wire logic        temp_select,
  input  wire logic        clock_source_select,
  input  wire logic        sleep_reset_pin,
  input  wire logic        sclk,
  input  wire logic [23:0] conv_code,
  input  wire logic [23:0] temp_code,
  output logic             dout_rdy_o,
  output logic             dout_rdy_oe,
  output logic             bridge_supply_switch,
  output logic             osc_enable,
  output logic             mod_reset,
  output logic [1:0]       gain_code,
  output logic [7:0]       gain_factor,
  output logic             pair_route,
  output logic             temp_route
);
  import acsq_pkg::*;

  typedef struct packed {
    acsq_state_t  st;
    logic [8:0]   sync1;
    logic [8:0]   sync2;
    logic         sclk_prev;
    logic [6:0]   cfg;
    logic [23:0]  cnt;
    logic [2:0]   settle;
    logic [3:0]   pd_cnt;
    logic         mod_reset;
    logic         osc_en;
    logic         bridge;
    logic         oe;
    logic [7:0]   gain_x;
    logic         pair;
    logic         temp;
    logic [23:0]  data;
    logic [31:0]  conv_total;
    logic         inject_en;
    logic         restart_req;
    logic [23:0]  inject;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    logic         load;
    logic         abort;
    logic [23:0]  word;
    logic         sclk_rise;
    logic         sclk_fall;
  } acsq_top_state_t;

  acsq_top_state_t state_reg;
  acsq_top_state_t state_next;
  acsq_ser_if      ser ();

  logic [8:0]  pins;
  logic [23:0] period;
  logic [23:0] source;
  logic        cfg_change;
  logic        power_dn;
  logic        internal_clk;
  logic        apb_wr;
  logic        apb_setup;
  logic [6:0]  cfg_now;

  assign pins = {sleep_reset_pin, clock_source_select, temp_select, input_pair_select,
                 gain_select_high, gain_select_low, rate_select_high, rate_select_low, sclk};

  always_comb begin
    cfg_now      = state_reg.sync2[PIN_CLOCK_SOURCE_SELECT:PIN_RATE_LO];
    cfg_change   = (cfg_now != state_reg.cfg);
    internal_clk = state_reg.sync2[PIN_CLOCK_SOURCE_SELECT];
    power_dn     = (state_reg.pd_cnt >= SLEEP_RESET_PIN_MIN_CYC);
    apb_setup    = psel && !penable;
    apb_wr       = psel && penable && pwrite && state_reg.pready;
    case (state_reg.cfg[PIN_RATE_HI-1:PIN_RATE_LO-1])
      RATE_CODE_10:  period = PERIOD_10_CYC;
      RATE_CODE_50:  period = PERIOD_50_CYC;
      RATE_CODE_60:  period = PERIOD_60_CYC;
      default:       period = PERIOD_120_CYC;
    endcase
    // Temperature path wins over the pair select
    if (state_reg.inject_en) begin
      source = state_reg.inject;
    end else if (state_reg.temp) begin
      source = temp_code;
    end else begin
      source = conv_code;
    end
  end

  always_comb begin
    state_next           = state_reg;
    state_next.sync1     = pins;
    state_next.sync2     = state_reg.sync1;
    state_next.sclk_prev = state_reg.sync2[PIN_SCLK];
    state_next.sclk_rise = state_reg.sync2[PIN_SCLK] && !state_reg.sclk_prev;
    state_next.sclk_fall = !state_reg.sync2[PIN_SCLK] && state_reg.sclk_prev;
    state_next.cfg       = cfg_now;
    state_next.load      = 1'b0;
    state_next.abort     = 1'b0;
    state_next.mod_reset = 1'b0;
    state_next.pair      = cfg_now[PIN_PAIR-1];
    state_next.temp      = cfg_now[PIN_TEMP-1];
    case (cfg_now[PIN_GAIN_HI-1:PIN_GAIN_LO-1])
      GAIN_CODE_1:  state_next.gain_x = GAIN_X1;
      GAIN_CODE_8:  state_next.gain_x = GAIN_X8;
      GAIN_CODE_64: state_next.gain_x = GAIN_X64;
      default:      state_next.gain_x = GAIN_X128;
    endcase

    // A short glitch on the sleep pin is not taken as a reset
    if (state_reg.sync2[PIN_SLEEP]) begin
      if (state_reg.pd_cnt < SLEEP_RESET_PIN_MIN_CYC) begin
        state_next.pd_cnt = state_reg.pd_cnt + 4'h1;
      end
    end else begin
      state_next.pd_cnt = 4'h0;
    end

    case (state_reg.st)
      ST_DOWN: begin
        state_next.oe        = 1'b0;
        state_next.bridge    = 1'b0;
        state_next.osc_en    = !internal_clk;
        state_next.abort     = 1'b1;
        state_next.mod_reset = 1'b1;
        state_next.cnt       = 24'h00_0000;
        state_next.settle    = 3'h0;
        if (!state_reg.sync2[PIN_SLEEP]) begin
          state_next.bridge = 1'b1;
          state_next.osc_en = 1'b1;
          if (internal_clk) begin
            state_next.st = ST_WAKE;
          end else begin
            state_next.st = ST_SETTLE;
            state_next.oe = 1'b1;
          end
        end
      end
      ST_WAKE: begin
        state_next.osc_en = 1'b1;
        state_next.bridge = 1'b1;
        state_next.cnt    = state_reg.cnt + 24'h00_0001;
        // Output stays tristated until the oscillator has started
        if (!internal_clk || state_reg.cnt >= WAKE_CYC - 24'h00_0001) begin
          state_next.st     = ST_SETTLE;
          state_next.oe     = 1'b1;
          state_next.cnt    = 24'h00_0000;
          state_next.settle = 3'h0;
        end
      end
      ST_SETTLE: begin
        state_next.cnt = state_reg.cnt + 24'h00_0001;
        if (state_reg.cnt >= period - 24'h00_0001) begin
          state_next.cnt    = 24'h00_0000;
          state_next.settle = state_reg.settle + 3'h1;
          if (state_reg.settle == SETTLE_CONV - 3'h1) begin
            state_next.st         = ST_RUN;
            state_next.data       = source;
            state_next.word       = source;
            state_next.load       = 1'b1;
            state_next.conv_total = state_reg.conv_total + 32'h0000_0001;
          end
        end
      end
      ST_RUN: begin
        state_next.cnt = state_reg.cnt + 24'h00_0001;
        if (state_reg.cnt >= period - 24'h00_0001) begin
          state_next.cnt        = 24'h00_0000;
          state_next.data       = source;
          state_next.word       = source;
          state_next.load       = 1'b1;
          state_next.conv_total = state_reg.conv_total + 32'h0000_0001;
        end else if (state_reg.cnt == period - RDY_GAP_CYC && !ser.busy) begin
          // Unread word is withdrawn so no read straddles the update
          state_next.abort = 1'b1;
        end
      end
      default: begin
        state_next.st = ST_DOWN;
      end
    endcase

    // Any configuration change restarts modulator and filter at once
    if (state_reg.st == ST_SETTLE || state_reg.st == ST_RUN) begin
      if (cfg_change || state_reg.restart_req) begin
        state_next.st        = ST_SETTLE;
        state_next.cnt       = 24'h00_0000;
        state_next.settle    = 3'h0;
        state_next.load      = 1'b0;
        state_next.abort     = 1'b1;
        state_next.mod_reset = 1'b1;
      end
    end
    state_next.restart_req = 1'b0;

    if (power_dn) begin
      state_next.st        = ST_DOWN;
      state_next.oe        = 1'b0;
      state_next.bridge    = 1'b0;
      state_next.load      = 1'b0;
      state_next.abort     = 1'b1;
      state_next.mod_reset = 1'b1;
    end

    // APB slave: answer registered in setup, zero wait states
    state_next.pready = apb_setup;
    if (apb_setup) begin
      state_next.pslverr = 1'b0;
      case (paddr)
        REG_CTRL:   state_next.prdata = {30'h0000_0000, 1'b0, state_reg.inject_en};
        REG_INJECT: state_next.prdata = {8'h00, state_reg.inject};
        REG_DATA:   state_next.prdata = {8'h00, state_reg.data};
        REG_STATUS: state_next.prdata = {16'h0000, state_reg.cfg, state_reg.settle,
                                         ser.busy, ser.dout, state_reg.st};
        REG_COUNT:  state_next.prdata = state_reg.conv_total;
        default: begin
          state_next.prdata  = 32'h0000_0000;
          state_next.pslverr = 1'b1;
        end
      endcase
    end else begin
      state_next.prdata  = 32'h0000_0000;
      state_next.pslverr = 1'b0;
    end
    if (apb_wr) begin
      case (paddr)
        REG_CTRL: begin
          state_next.inject_en   = pwdata[CTRL_INJECT];
          state_next.restart_req = pwdata[CTRL_RESTART];
        end
        REG_INJECT: begin
          state_next.inject = pwdata[23:0];
        end
        default: begin
          state_next.inject_en = state_reg.inject_en;
        end
      endcase
    end
  end

  // Reset lands in the wake state; serial clock taps preset to its idle high, so no false edge
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_reg <= '{st: ST_WAKE, sync1: 9'h001, sync2: 9'h001, sclk_prev: 1'b1, cfg: 7'h00,
                     cnt: 24'h00_0000, settle: 3'h0, pd_cnt: 4'h0, mod_reset: 1'b1,
                     osc_en: 1'b1, bridge: 1'b1, oe: 1'b0, gain_x: GAIN_X1, pair: 1'b0,
                     temp: 1'b0, data: CODE_ZERO, conv_total: 32'h0000_0000, inject_en: 1'b0,
                     restart_req: 1'b0, inject: CODE_ZERO, prdata: 32'h0000_0000,
                     pready: 1'b0, pslverr: 1'b0, load: 1'b0, abort: 1'b1,
                     word: CODE_ZERO, sclk_rise: 1'b0, sclk_fall: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign ser.sclk_rise = state_reg.sclk_rise;
  assign ser.sclk_fall = state_reg.sclk_fall;
  assign ser.load      = state_reg.load;
  assign ser.abort     = state_reg.abort;
  assign ser.word      = state_reg.word;

  acsq_shift u_shift (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .ser      (ser.shf)
  );

  assign prdata               = state_reg.prdata;
  assign pready               = state_reg.pready;
  assign pslverr              = state_reg.pslverr;
  assign dout_rdy_o           = ser.dout;
  assign dout_rdy_oe          = state_reg.oe;
  assign bridge_supply_switch = state_reg.bridge;
  assign osc_enable           = state_reg.osc_en;
  assign mod_reset            = state_reg.mod_reset;
  assign gain_code            = state_reg.cfg[PIN_GAIN_HI-1:PIN_GAIN_LO-1];
  assign gain_factor          = state_reg.gain_x;
  assign pair_route           = state_reg.pair;
  assign temp_route           = state_reg.temp;
endmodule

// File: acsq_props.sv
`timescale 1ns/100ps
module acsq_props #(
  parameter logic [23:0] PERIOD_120_CYC = 24'h00_041A
) (
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        input_pair_select,
  input wire logic        temp_select,
  input wire logic        clock_source_select,
  input wire logic        sleep_reset_pin,
  input wire logic        dout_rdy_o,
  input wire logic        dout_rdy_oe,
  input wire logic        bridge_supply_switch,
  input wire logic        osc_enable,
  input wire logic        mod_reset,
  input wire logic [1:0]  gain_code,
  input wire logic [7:0]  gain_factor,
  input wire logic        pair_route,
  input wire logic        temp_route
);
  // Quiet time is measured against the fastest rate, so it is only a lower bound
  logic [15:0] quiet_cnt;
  logic [4:0]  sleep_cnt;
  always_ff @(posedge core_clk) begin
    quiet_cnt <= (sys_rst || mod_reset) ? 16'h0000 : quiet_cnt + 16'(quiet_cnt != 16'hFFFF);
    sleep_cnt <= (sys_rst || !sleep_reset_pin) ? 5'h00 : sleep_cnt + 5'(sleep_cnt != 5'h1F);
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_apb_zero_wait: assert property (psel && !penable && !pready |=> pready ##1 !pready)
    else $error("pready not one cycle after setup");
  a_apb_err_map: assert property (pready && paddr > 8'h10 |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  a_gain_decode: assert property (gain_code == $past(gain_code) |-> gain_factor == (gain_code == 2'h0 ? 8'h01 :
    gain_code == 2'h1 ? 8'h08 : gain_code == 2'h2 ? 8'h40 : 8'h80)) else $error("gain factor wrong");
  a_pair_route: assert property ((bridge_supply_switch && $stable(input_pair_select))[*6] |->
    pair_route == input_pair_select) else $error("pair route wrong");
  a_temp_route: assert property ((bridge_supply_switch && $stable(temp_select))[*6] |->
    temp_route == temp_select) else $error("temperature route wrong");
  a_crystal_osc: assert property ((!clock_source_select)[*6] |-> osc_enable) else $error("oscillator stopped");
  a_settle_hold: assert property (dout_rdy_oe && quiet_cnt < 16'(4 * PERIOD_120_CYC - 8) |-> dout_rdy_o)
    else $error("ready low before settling");
  a_fall_active: assert property ($fell(dout_rdy_o) |-> dout_rdy_oe && bridge_supply_switch && !mod_reset)
    else $error("ready fell while inactive");
  a_sleep_open: assert property (sleep_cnt == 5'h10 |-> !bridge_supply_switch && !dout_rdy_oe && mod_reset)
    else $error("power-down not entered");
  a_open_tristate: assert property (!bridge_supply_switch |-> !dout_rdy_oe) else $error("output driven in sleep");
  cover property ($fell(dout_rdy_o));
  cover property (pslverr);
  cover property (!bridge_supply_switch && !osc_enable);
endmodule
bind acsq_top acsq_props #(.PERIOD_120_CYC(PERIOD_120_CYC)) u_props (.core_clk, .sys_rst, .psel, .penable, .paddr,
  .prdata, .pready, .pslverr, .input_pair_select, .temp_select, .clock_source_select, .sleep_reset_pin, .dout_rdy_o,
  .dout_rdy_oe, .bridge_supply_switch, .osc_enable, .mod_reset, .gain_code, .gain_factor, .pair_route, .temp_route);

// File: acsq_host_model.sv
`timescale 1ns/100ps
module acsq_host_model (
  input wire logic    dout_rdy_o,
  input wire logic    dout_rdy_oe,
  input wire logic    read_en,
  output logic        sclk,
  output logic [23:0] word,
  output int          n_words
);
  // No pull-up: a released line shows the inverse, never a stale level
  logic line;
  assign line = dout_rdy_oe ? dout_rdy_o : !dout_rdy_o;
  // Serial clock idles high and runs only inside a read
  initial begin
    sclk = 1'b1;
    word = 24'h00_0000;
    n_words = 0;
    forever begin
      @(negedge line);
      if (dout_rdy_oe && read_en) begin
        #3; // Off the core edge so the synchroniser never sees a tie
        for (int i = 23; i >= 0; i--) begin
          sclk = 1'b0;
          #80;
          sclk = 1'b1;
          word[i] = line;
          #80;
        end
        n_words = n_words + 1;
      end
    end
  end
endmodule

// File: tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import acsq_pkg::*;
  logic        core_clk = 1'b0;
  logic        sys_rst  = 1'b1;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h0000_0000;
  logic [1:0]  rate     = 2'h0;
  logic [1:0]  gain     = 2'h0;
  logic        pair = 1'b0, temp = 1'b0, csel = 1'b0, sleep = 1'b0, read_en = 1'b1;
  logic [23:0] conv     = 24'h12_3456;
  logic [23:0] tcode    = 24'h83_2A10;
  logic [31:0] prdata, r;
  logic        pready, pslverr, e, dout, oe, bridge, osc, mres, proute, troute, sclk;
  logic [1:0]  gcode;
  logic [7:0]  gfac;
  logic [23:0] word;
  logic [23:0] per [4]  = '{24'h00_041A, 24'h00_044C, 24'h00_04B0, 24'h00_07D0};
  logic [7:0]  facs [4] = '{8'h01, 8'h08, 8'h40, 8'h80};
  logic [23:0] codes [3] = '{24'h00_0000, 24'h80_0000, 24'hFF_FFFF};
  int          nw, c, k, n_fail = 0, cmp_count = 0;
  always #5 core_clk = ~core_clk;
  acsq_top #(.PERIOD_10_CYC(24'h00_07D0), .PERIOD_50_CYC(24'h00_04B0), .PERIOD_60_CYC(24'h00_044C),
    .PERIOD_120_CYC(24'h00_041A), .WAKE_CYC(24'h00_00C8)) uut (.core_clk, .sys_rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .rate_select_low(rate[0]), .rate_select_high(rate[1]),
    .gain_select_low(gain[0]), .gain_select_high(gain[1]), .input_pair_select(pair), .temp_select(temp),
    .clock_source_select(csel), .sleep_reset_pin(sleep), .sclk, .conv_code(conv), .temp_code(tcode),
    .dout_rdy_o(dout), .dout_rdy_oe(oe), .bridge_supply_switch(bridge), .osc_enable(osc), .mod_reset(mres),
    .gain_code(gcode), .gain_factor(gfac), .pair_route(proute), .temp_route(troute));
  acsq_host_model host (.dout_rdy_o(dout), .dout_rdy_oe(oe), .read_en, .sclk, .word, .n_words(nw));
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin
      chk(32'h0, 32'h1);
      finish_test();
    end
  endtask
  // Counts edges until the host model finishes its next read
  task automatic wword;
    int n0;
    n0 = nw;
    c = 0;
    while (nw == n0 && c < 40000) begin
      @(posedge core_clk);
      c++;
    end
    if (c >= 40000) begin
      chk(32'h0, 32'h1);
      finish_test();
    end
  endtask
  // First result after a full settle, then exactly one period apart
  task automatic settle_chk(input int p);
    wword();
    chk(32'(c >= 4 * p && c <= 4 * p + 600), 32'h1);
    wword();
    chk(32'(c), 32'(p));
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    apb(1'b1, REG_INJECT, 32'h00A5_5A5A);
    apb(1'b0, REG_INJECT, 32'h0000_0000);
    chk(r, 32'h00A5_5A5A);
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk({r[30:0], e}, 32'h0000_0001);
    for (int i = 3; i >= 0; i--) begin
      @(posedge core_clk);
      rate <= 2'(i);
      settle_chk(per[i]);
      chk(32'(word), 32'(conv));
    end
    apb(1'b0, REG_DATA, 32'h0000_0000);
    chk(r, {8'h00, conv});
    foreach (codes[j]) begin
      conv <= codes[j];
      wword();
      wword();
      chk(32'(word), 32'(codes[j]));
    end
    apb(1'b1, REG_CTRL, 32'h0000_0003);
    apb(1'b0, REG_CTRL, 32'h0000_0000);
    chk(r, 32'h0000_0001);
    settle_chk(1050);
    chk(32'(word), 32'h00A5_5A5A);
    apb(1'b1, REG_CTRL, 32'h0000_0000);
    for (int g = 3; g >= 0; g--) begin
      @(posedge core_clk);
      gain <= 2'(g);
      repeat (6) @(posedge core_clk);
      chk({22'h0, gcode, gfac}, {22'h0, 2'(g), facs[g]});
    end
    settle_chk(1050);
    pair <= 1'b1;
    settle_chk(1050);
    temp <= 1'b1;
    settle_chk(1050);
    chk(32'(word), 32'(tcode));
    temp <= 1'b0;
    settle_chk(1050);
    chk(32'(word), 32'(conv));
    for (int s = 1; s >= 0; s--) begin
      csel <= s[0];
      settle_chk(1050);
      sleep <= 1'b1;
      repeat (20) @(posedge core_clk);
      chk(32'({osc, oe, bridge}), 32'({~s[0], 2'b00}));
      sleep <= 1'b0;
      repeat (30) @(posedge core_clk);
      chk(32'(oe), 32'(!s[0]));
      repeat (200) @(posedge core_clk);
      chk(32'({oe, bridge}), 32'h3);
      wword();
      wword();
      chk(32'(c), 32'h0000_041A);
    end
    sleep <= 1'b1;
    repeat (5) @(posedge core_clk);
    sleep <= 1'b0;
    repeat (10) @(posedge core_clk);
    chk(32'({oe, bridge}), 32'h3);
    read_en <= 1'b0;
    k = 0;
    while (dout !== 1'b0 && k < 3000) begin
      @(posedge core_clk);
      k++;
    end
    chk(32'(dout), 32'h0);
    repeat (550) @(posedge core_clk);
    chk(32'(dout), 32'h1);
    read_en <= 1'b1;
    finish_test();
  end
endmodule
